// ===== core/dis_pkg.sv
// Constants, field layouts and types shared by the DMA, interrupt and suspend sideband block
package dis_pkg;

   // ==========================================================
   // Register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] HCFG_RD_ADDR = 8'h20;
   localparam logic [ADDR_W-1:0] HCFG_WR_ADDR = 8'ha0;
   localparam logic [ADDR_W-1:0] PCFG_WR_ADDR = 8'hba;
   localparam logic [ADDR_W-1:0] PCFG_RD_ADDR = 8'hbb;
   localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 8'h40;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h41;
   localparam logic [ADDR_W-1:0] SUSP_CTRL_ADDR = 8'h42;

   // ==========================================================
   // Hardware configuration fields (same layout for host and peripheral)
   localparam int CFG_W = 6;
   localparam int CFG_MRG_IRQ = 0;
   localparam int CFG_MRG_DMA = 1;
   localparam int CFG_DREQ_POL = 2;
   localparam int CFG_DACK_POL = 3;
   localparam int CFG_IRQ_POL = 4;
   localparam int CFG_IRQ_EN = 5;
   localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;

   typedef struct packed {
      logic irqEn;
      logic irqPol;
      logic dackPol;
      logic dreqPol;
      logic mrgDma;
      logic mrgIrq;
   } dis_cfg_s;

   // ==========================================================
   // Interrupt status and mask fields
   localparam int NUM_IRQ = 4;
   localparam int ST_HOST_EVT = 0;
   localparam int ST_PERIPH_EVT = 1;
   localparam int ST_HOST_WAKE = 2;
   localparam int ST_PERIPH_WAKE = 3;
   localparam logic [NUM_IRQ-1:0] HOST_GROUP = 4'h5;
   localparam logic [NUM_IRQ-1:0] PERIPH_GROUP = 4'ha;
   localparam logic [NUM_IRQ-1:0] IRQ_RESET = 4'h0;

   // ==========================================================
   // Suspend control fields
   localparam int SUSP_HOST_BIT = 0;
   localparam int SUSP_PERIPH_BIT = 1;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SW_CNT_W = 8;
   localparam int SETTLE_NS = 1000;
   localparam int RESUME_NS = 1000;
   localparam logic [SW_CNT_W-1:0] SETTLE_CYC = 8'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [SW_CNT_W-1:0] RESUME_CYC = 8'((RESUME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [SW_CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [SW_CNT_W-1:0] CNT_ONE = 8'h01;

   typedef enum logic [1:0] {
      SW_AWAKE = 2'b00,
      SW_SUSPEND = 2'b01,
      SW_RESUME = 2'b11
   } dis_sw_e;

endpackage

// ===== core/dis_sideband.sv
// DMA request/grant, interrupt and suspend/wake sideband of the dual-role controller
// Summary of operation
// RULE1: Peripheral DMA request pin asserts when peripheral needs transfer, polarity from peripheral config.
// RULE2: Host DMA grant pin is decoded with host config polarity.
// RULE3: Peripheral DMA grant pin is decoded with peripheral config polarity.
// RULE4: Host interrupt pin signals host events, controlled by host config.
// RULE5: Merged interrupt bit routes host and peripheral interrupts onto host interrupt pin.
// RULE6: Peripheral interrupt pin signals peripheral events, controlled by peripheral config.
// RULE7: Host sleep/wake pin released high while host controller is suspended.
// RULE8: External low pulse on host sleep/wake pin wakes the host controller.
// RULE9: Peripheral sleep/wake pin released high while peripheral controller is suspended.
// RULE10: External low pulse on peripheral sleep/wake pin wakes the peripheral controller.
// RULE11: During reset, all other inputs stay stable at inactive levels.
// RULE12: Host DMA request pin asserts when host needs transfer, polarity from host config.
// RULE13: Merged DMA bit routes both channels onto host DMA request and grant pins.
// RULE14: After wake-up, suspend indication ends once the controller has resumed.
`timescale 1ns/1ps
`default_nettype none
module dis_sideband
   import dis_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdData,
   input wire logic hostDmaNeed,
   input wire logic periphDmaNeed,
   output logic hostDmaGranted,
   output logic periphDmaGranted,
   output logic hostDmaRequest,
   output logic periphDmaRequest,
   input wire logic hostDmaGrant,
   input wire logic periphDmaGrant,
   input wire logic hostEvent,
   input wire logic periphEvent,
   output logic hostIrqOut,
   output logic periphIrqOut,
   input wire logic hostSuspendEnter,
   input wire logic periphSuspendEnter,
   output logic hostSuspended,
   output logic periphSuspended,
   output logic hostWake,
   output logic periphWake,
   input wire logic hostSleepWakeIn,
   output logic hostSleepWakeOut,
   output logic hostSleepWakeOe,
   input wire logic periphSleepWakeIn,
   output logic periphSleepWakeOut,
   output logic periphSleepWakeOe,
   output logic irqOut
);
   // Pin level for a logical active state under a polarity bit (1 = active high);
   // the same relation decodes an incoming pin
   function automatic logic applyPol(input logic active, input logic pol);
      applyPol = pol ? active : ~active;
   endfunction

   function automatic dis_cfg_s toCfg(input logic [CFG_W-1:0] raw);
      toCfg.irqEn = raw[CFG_IRQ_EN];
      toCfg.irqPol = raw[CFG_IRQ_POL];
      toCfg.dackPol = raw[CFG_DACK_POL];
      toCfg.dreqPol = raw[CFG_DREQ_POL];
      toCfg.mrgDma = raw[CFG_MRG_DMA];
      toCfg.mrgIrq = raw[CFG_MRG_IRQ];
   endfunction

   function automatic logic [CFG_W-1:0] fromCfg(input dis_cfg_s c);
      fromCfg = '0;
      fromCfg[CFG_IRQ_EN] = c.irqEn;
      fromCfg[CFG_IRQ_POL] = c.irqPol;
      fromCfg[CFG_DACK_POL] = c.dackPol;
      fromCfg[CFG_DREQ_POL] = c.dreqPol;
      fromCfg[CFG_MRG_DMA] = c.mrgDma;
      fromCfg[CFG_MRG_IRQ] = c.mrgIrq;
   endfunction

   dis_cfg_s hcfg_ff;
   dis_cfg_s pcfg_ff;
   logic [NUM_IRQ-1:0] irqStat_ff;
   logic [NUM_IRQ-1:0] irqMask_ff;
   logic [NUM_IRQ-1:0] irqSet;
   logic [NUM_IRQ-1:0] irqPend;
   logic [DATA_W-1:0] nxt_regRdData;
   logic hostGrantSync;
   logic periphGrantSync;
   logic hostPinSync;
   logic periphPinSync;
   logic hostGrantAct;
   logic periphGrantAct;
   logic hostIrqAct;
   logic periphIrqAct;
   logic hostSuspWr;
   logic periphSuspWr;

   // ==========================================================
   // Pin synchronisers
   // RULE11 reset values match idle pins
   dis_sync2 #(
      .W(4),
      .RST_VAL(4'hf)
   ) u_pin_sync (
      .clock(clock),
      .srst(srst),
      .din({hostDmaGrant, periphDmaGrant, hostSleepWakeIn, periphSleepWakeIn}),
      .dout({hostGrantSync, periphGrantSync, hostPinSync, periphPinSync})
   );

   // ==========================================================
   // Configuration registers
   always_ff @(posedge clock) begin
      if (srst) begin
         hcfg_ff <= toCfg(CFG_RESET);
      end else if (regWr && regAddr == HCFG_WR_ADDR) begin
         hcfg_ff <= toCfg(regWrData[CFG_W-1:0]);
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pcfg_ff <= toCfg(CFG_RESET);
      end else if (regWr && regAddr == PCFG_WR_ADDR) begin
         pcfg_ff <= toCfg(regWrData[CFG_W-1:0]);
      end
   end

   // ==========================================================
   // Interrupt status and mask
   always_comb begin
      irqSet = IRQ_RESET;
      irqSet[ST_HOST_EVT] = hostEvent;
      irqSet[ST_PERIPH_EVT] = periphEvent;
      irqSet[ST_HOST_WAKE] = hostWake;
      irqSet[ST_PERIPH_WAKE] = periphWake;
   end

   // Write one to clear; an event in the clearing cycle still sets the bit
   always_ff @(posedge clock) begin
      if (srst) begin
         irqStat_ff <= IRQ_RESET;
      end else if (regWr && regAddr == IRQ_STAT_ADDR) begin
         irqStat_ff <= (irqStat_ff & ~regWrData[NUM_IRQ-1:0]) | irqSet;
      end else begin
         irqStat_ff <= irqStat_ff | irqSet;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         irqMask_ff <= IRQ_RESET;
      end else if (regWr && regAddr == IRQ_MASK_ADDR) begin
         irqMask_ff <= regWrData[NUM_IRQ-1:0];
      end
   end

   assign irqPend = irqStat_ff & irqMask_ff;
   assign irqOut = |irqPend;

   // ==========================================================
   // Interrupt pins
   always_comb begin
      // RULE4 host events on host pin
      hostIrqAct = hcfg_ff.irqEn & |(irqPend & HOST_GROUP);
      periphIrqAct = 1'b0;
      // RULE5 merged interrupt onto host pin
      if (hcfg_ff.mrgIrq) begin
         hostIrqAct = hcfg_ff.irqEn & |(irqPend & (HOST_GROUP | PERIPH_GROUP));
      // RULE6 peripheral events on own pin
      end else begin
         periphIrqAct = pcfg_ff.irqEn & |(irqPend & PERIPH_GROUP);
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         hostIrqOut <= applyPol(1'b0, CFG_RESET[CFG_IRQ_POL]);
         periphIrqOut <= applyPol(1'b0, CFG_RESET[CFG_IRQ_POL]);
      end else begin
         hostIrqOut <= applyPol(hostIrqAct, hcfg_ff.irqPol);
         periphIrqOut <= applyPol(periphIrqAct, pcfg_ff.irqPol);
      end
   end

   // ==========================================================
   // DMA request and grant
   // RULE2 host grant polarity
   assign hostGrantAct = applyPol(hostGrantSync, hcfg_ff.dackPol);
   // RULE3 peripheral grant polarity
   assign periphGrantAct = applyPol(periphGrantSync, pcfg_ff.dackPol);

   always_ff @(posedge clock) begin
      if (srst) begin
         hostDmaRequest <= applyPol(1'b0, CFG_RESET[CFG_DREQ_POL]);
         periphDmaRequest <= applyPol(1'b0, CFG_RESET[CFG_DREQ_POL]);
      end else if (hcfg_ff.mrgDma) begin
         // RULE13 both channels on host pins
         hostDmaRequest <= applyPol(hostDmaNeed | periphDmaNeed, hcfg_ff.dreqPol);
         periphDmaRequest <= applyPol(1'b0, pcfg_ff.dreqPol);
      end else begin
         // RULE12 host request with polarity
         hostDmaRequest <= applyPol(hostDmaNeed, hcfg_ff.dreqPol);
         // RULE1 peripheral request with polarity
         periphDmaRequest <= applyPol(periphDmaNeed, pcfg_ff.dreqPol);
      end
   end

   // Merged grants go to the host channel first; a shared line cannot tell the two apart
   always_ff @(posedge clock) begin
      if (srst) begin
         hostDmaGranted <= 1'b0;
         periphDmaGranted <= 1'b0;
      end else if (hcfg_ff.mrgDma) begin
         // RULE13 shared grant pin
         hostDmaGranted <= hostGrantAct & hostDmaNeed;
         periphDmaGranted <= hostGrantAct & periphDmaNeed & ~hostDmaNeed;
      end else begin
         hostDmaGranted <= hostGrantAct & hostDmaNeed;
         periphDmaGranted <= periphGrantAct & periphDmaNeed;
      end
   end

   // ==========================================================
   // Suspend and wake
   assign hostSuspWr = regWr && regAddr == SUSP_CTRL_ADDR && regWrData[SUSP_HOST_BIT];
   assign periphSuspWr = regWr && regAddr == SUSP_CTRL_ADDR && regWrData[SUSP_PERIPH_BIT];

   // RULE7 host suspend indication
   dis_sleep_wake u_host_sw (
      .clock(clock),
      .srst(srst),
      .enterSuspend(hostSuspendEnter | hostSuspWr),
      .pinSync(hostPinSync),
      .pinOut(hostSleepWakeOut),
      .pinOe(hostSleepWakeOe),
      .suspended(hostSuspended),
      .wakeEvent(hostWake)
   );

   // RULE9 peripheral suspend indication
   dis_sleep_wake u_periph_sw (
      .clock(clock),
      .srst(srst),
      .enterSuspend(periphSuspendEnter | periphSuspWr),
      .pinSync(periphPinSync),
      .pinOut(periphSleepWakeOut),
      .pinOe(periphSleepWakeOe),
      .suspended(periphSuspended),
      .wakeEvent(periphWake)
   );

   // ==========================================================
   // Register read
   always_comb begin
      nxt_regRdData = '0;
      case (regAddr)
         HCFG_RD_ADDR: nxt_regRdData[CFG_W-1:0] = fromCfg(hcfg_ff);
         PCFG_RD_ADDR: nxt_regRdData[CFG_W-1:0] = fromCfg(pcfg_ff);
         IRQ_STAT_ADDR: nxt_regRdData[NUM_IRQ-1:0] = irqStat_ff;
         IRQ_MASK_ADDR: nxt_regRdData[NUM_IRQ-1:0] = irqMask_ff;
         SUSP_CTRL_ADDR: begin
            nxt_regRdData[SUSP_HOST_BIT] = hostSuspended;
            nxt_regRdData[SUSP_PERIPH_BIT] = periphSuspended;
         end
         default: nxt_regRdData = '0;
      endcase
   end

   // Read data stands for the one cycle after the strobe, zero otherwise
   always_ff @(posedge clock) begin
      if (srst) begin
         regRdData <= '0;
      end else if (regRd) begin
         regRdData <= nxt_regRdData;
      end else begin
         regRdData <= '0;
      end
   end

   // ==========================================================
   // Checks
   a_pdreq_polarity: assert property (@(posedge clock) disable iff (srst) // RULE1
      (periphDmaNeed && !hcfg_ff.mrgDma) |=> periphDmaRequest == $past(pcfg_ff.dreqPol))
      else $error("peripheral DMA request at wrong level");
   a_hgrant_decode: assert property (@(posedge clock) disable iff (srst) // RULE2
      (hostDmaNeed && hostGrantSync == hcfg_ff.dackPol) |=> hostDmaGranted)
      else $error("host grant not decoded");
   a_pgrant_decode: assert property (@(posedge clock) disable iff (srst) // RULE3
      (!hcfg_ff.mrgDma && periphDmaNeed && periphGrantSync != pcfg_ff.dackPol) |=> !periphDmaGranted)
      else $error("inactive peripheral grant seen as granted");
   a_hirq_level: assert property (@(posedge clock) disable iff (srst) // RULE4
      (hcfg_ff.irqEn && |(irqPend & HOST_GROUP)) |=> hostIrqOut == $past(hcfg_ff.irqPol))
      else $error("host interrupt pin not active");
   a_merged_irq: assert property (@(posedge clock) disable iff (srst) // RULE5
      (hcfg_ff.mrgIrq && hcfg_ff.irqEn && |(irqPend & PERIPH_GROUP))
      |=> (hostIrqOut == $past(hcfg_ff.irqPol) && periphIrqOut != $past(pcfg_ff.irqPol)))
      else $error("merged interrupt not routed to host pin");
   a_pirq_level: assert property (@(posedge clock) disable iff (srst) // RULE6
      (!hcfg_ff.mrgIrq && pcfg_ff.irqEn && |(irqPend & PERIPH_GROUP)) |=> periphIrqOut == $past(pcfg_ff.irqPol))
      else $error("peripheral interrupt pin not active");
   a_host_susp_pin: assert property (@(posedge clock) disable iff (srst) // RULE7
      hostSuspended |-> !hostSleepWakeOe)
      else $error("host pin driven low while suspended");
   a_periph_susp_pin: assert property (@(posedge clock) disable iff (srst) // RULE9
      $rose(periphSuspended) |-> !periphSleepWakeOe && $past(periphSleepWakeOe))
      else $error("peripheral pin not released on suspend");
   a_hdreq_level: assert property (@(posedge clock) disable iff (srst) // RULE12
      hostDmaNeed |=> hostDmaRequest == $past(hcfg_ff.dreqPol))
      else $error("host DMA request at wrong level");
   a_merged_dma: assert property (@(posedge clock) disable iff (srst) // RULE13
      (hcfg_ff.mrgDma && periphDmaNeed)
      |=> (hostDmaRequest == $past(hcfg_ff.dreqPol) && periphDmaRequest != $past(pcfg_ff.dreqPol)))
      else $error("merged DMA not routed to host pin");
   a_irq_set_wins: assert property (@(posedge clock) disable iff (srst)
      (hostEvent && regWr && regAddr == IRQ_STAT_ADDR) |=> irqStat_ff[ST_HOST_EVT])
      else $error("event lost against clear");
endmodule
`default_nettype wire

// ===== core/dis_sleep_wake.sv
// Suspend indication and wake-up detection for one open-drain sleep/wake pin
`timescale 1ns/1ps
`default_nettype none
module dis_sleep_wake
   import dis_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic enterSuspend,
   input wire logic pinSync,
   output logic pinOut,
   output logic pinOe,
   output logic suspended,
   output logic wakeEvent
);
   localparam int RESUME_LIM = int'(RESUME_CYC) + 1;

   dis_sw_e state_ff;
   logic [SW_CNT_W-1:0] cnt_ff;

   // ==========================================================
   // State and timer
   always_ff @(posedge clock) begin
      if (srst) begin
         state_ff <= SW_AWAKE;
         cnt_ff <= CNT_ZERO;
         wakeEvent <= 1'b0;
      end else begin
         wakeEvent <= 1'b0;
         case (state_ff)
            SW_AWAKE: begin
               if (enterSuspend) begin
                  state_ff <= SW_SUSPEND;
                  cnt_ff <= SETTLE_CYC;
               end
            end
            SW_SUSPEND: begin
               // Pull-up needs time to lift the pin; a low before that is not a wake
               if (cnt_ff != CNT_ZERO) begin
                  cnt_ff <= cnt_ff - CNT_ONE;
               // RULE8 low pulse wakes
               end else if (!pinSync) begin
                  state_ff <= SW_RESUME;
                  cnt_ff <= RESUME_CYC;
                  wakeEvent <= 1'b1;
               end
            end
            SW_RESUME: begin
               // RULE14 leave after resume
               if (cnt_ff == CNT_ZERO) begin
                  state_ff <= SW_AWAKE;
               end else begin
                  cnt_ff <= cnt_ff - CNT_ONE;
               end
            end
            default: begin
               state_ff <= SW_AWAKE;
               cnt_ff <= CNT_ZERO;
            end
         endcase
      end
   end

   // Pin released (pulled high) while suspended or resuming, driven low when awake
   assign pinOut = 1'b0;
   assign pinOe = (state_ff == SW_AWAKE);
   assign suspended = (state_ff == SW_SUSPEND);

   a_wake_on_low: assert property (@(posedge clock) disable iff (srst) // RULE8
      (state_ff == SW_SUSPEND && cnt_ff == CNT_ZERO && !pinSync) |=> (wakeEvent && state_ff == SW_RESUME))
      else $error("low pulse on suspended pin did not wake");
   a_resume_ends: assert property (@(posedge clock) disable iff (srst) // RULE14
      $rose(state_ff == SW_RESUME) |-> ##[1:RESUME_LIM] pinOe)
      else $error("suspend indication not withdrawn after resume");
endmodule
`default_nettype wire

// ===== core/dis_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dis_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_ff;

   // First stage is read only by the second stage
   always_ff @(posedge clock) begin
      if (srst) begin
         meta_ff <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         meta_ff <= din;
         dout <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// ===== dv/dis_host_model.sv
// Behavioural DMA controller and external wake-up logic at the sideband pins
`timescale 1ns/1ps
`default_nettype none
module dis_host_model (
   input wire logic clock,
   input wire logic srst,
   input wire logic [3:0] pol,
   input wire logic hostReqPin,
   input wire logic periphReqPin,
   input wire logic [1:0] wakeCmd,
   output logic hostGrantPin,
   output logic periphGrantPin,
   output logic [1:0] wakeLow
);
   logic [2:0] lowCnt [2];

   // ==========================================================
   // Grant
   // grant answers an active request, idle in reset
   always_ff @(posedge clock) begin
      if (srst) begin
         hostGrantPin <= ~pol[1];
         periphGrantPin <= ~pol[3];
      end else begin
         hostGrantPin <= (hostReqPin == pol[0]) ? pol[1] : ~pol[1];
         periphGrantPin <= (periphReqPin == pol[2]) ? pol[3] : ~pol[3];
      end
   end

   // ==========================================================
   // Wake pulse
   // four-cycle low pulse, released otherwise
   always_ff @(posedge clock) begin
      for (int i = 0; i < 2; i++) begin
         if (srst) begin
            lowCnt[i] <= 3'h0;
         end else if (wakeCmd[i]) begin
            lowCnt[i] <= 3'h4;
         end else if (lowCnt[i] != 3'h0) begin
            lowCnt[i] <= lowCnt[i] - 3'h1;
         end
      end
   end
   assign wakeLow = {lowCnt[1] != 3'h0, lowCnt[0] != 3'h0};
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the DMA, interrupt and suspend sideband block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top
   import dis_pkg::*;
;
   logic clock = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0;
   logic [ADDR_W-1:0] regAddr = 8'h00;
   logic [DATA_W-1:0] regWrData = 16'h0000;
   logic hostDmaNeed = 1'b0, periphDmaNeed = 1'b0, hostEvent = 1'b0, periphEvent = 1'b0;
   logic hostSuspendEnter = 1'b0, periphSuspendEnter = 1'b0;
   logic [1:0] wakeCmd = 2'b00;
   logic [5:0] hCfg = 6'h00, pCfg = 6'h00;
   int err_total = 0, checks = 0, cycles = 0;
   wire logic [DATA_W-1:0] regRdData;
   wire logic hostDmaGranted, periphDmaGranted, hostDmaRequest, periphDmaRequest;
   wire logic hostDmaGrant, periphDmaGrant, hostIrqOut, periphIrqOut, irqOut;
   wire logic hostSuspended, periphSuspended, hostWake, periphWake;
   wire logic hostSleepWakeOut, hostSleepWakeOe, periphSleepWakeOut, periphSleepWakeOe;
   wire logic [1:0] wakeLow, swPin;
   // Pull-up on each open-drain pin: low only while someone drives it
   assign swPin[0] = ~((hostSleepWakeOe & ~hostSleepWakeOut) | wakeLow[0]);
   assign swPin[1] = ~((periphSleepWakeOe & ~periphSleepWakeOut) | wakeLow[1]);

   dis_sideband i_dis_sideband (.clock(clock), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .hostDmaNeed(hostDmaNeed),
      .periphDmaNeed(periphDmaNeed), .hostDmaGranted(hostDmaGranted), .periphDmaGranted(periphDmaGranted),
      .hostDmaRequest(hostDmaRequest), .periphDmaRequest(periphDmaRequest), .hostDmaGrant(hostDmaGrant),
      .periphDmaGrant(periphDmaGrant), .hostEvent(hostEvent), .periphEvent(periphEvent),
      .hostIrqOut(hostIrqOut), .periphIrqOut(periphIrqOut), .hostSuspendEnter(hostSuspendEnter),
      .periphSuspendEnter(periphSuspendEnter), .hostSuspended(hostSuspended),
      .periphSuspended(periphSuspended), .hostWake(hostWake), .periphWake(periphWake),
      .hostSleepWakeIn(swPin[0]), .hostSleepWakeOut(hostSleepWakeOut), .hostSleepWakeOe(hostSleepWakeOe),
      .periphSleepWakeIn(swPin[1]), .periphSleepWakeOut(periphSleepWakeOut),
      .periphSleepWakeOe(periphSleepWakeOe), .irqOut(irqOut));
   dis_host_model i_dis_host_model (.clock(clock), .srst(srst),
      .pol({pCfg[CFG_DACK_POL], pCfg[CFG_DREQ_POL], hCfg[CFG_DACK_POL], hCfg[CFG_DREQ_POL]}),
      .hostReqPin(hostDmaRequest), .periphReqPin(periphDmaRequest), .wakeCmd(wakeCmd),
      .hostGrantPin(hostDmaGrant), .periphGrantPin(periphDmaGrant), .wakeLow(wakeLow));

   always #5 clock = ~clock;

   // ==========================================================
   // Shared tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      if (a == HCFG_WR_ADDR) hCfg <= d[5:0];
      if (a == PCFG_WR_ADDR) pCfg <= d[5:0];
      @(posedge clock);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge clock);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd <= 1'b0;
      #1;
      `CHK(regRdData, e)
   endtask
   task automatic ev(input logic [1:0] m);
      @(posedge clock);
      {periphEvent, hostEvent} <= m;
      @(posedge clock);
      {periphEvent, hostEvent} <= 2'b00;
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      `CHK({hostIrqOut, periphIrqOut, hostDmaRequest, periphDmaRequest}, 4'hf) // idle pin levels
      `CHK({hostSleepWakeOe, hostSuspended, periphSuspended}, 3'b100) // awake after reset
      rd(HCFG_RD_ADDR, 16'h0000); // host config reset value
      rd(PCFG_RD_ADDR, 16'h0000); // peripheral config reset value
      wr(8'h7f, 16'hffff);
      rd(8'h7f, 16'h0000); // unmapped place reads zero
      $display("test reset done");
   endtask
   task automatic t_dma();
      logic pl;
      for (int p = 0; p < 2; p++) begin
         pl = 1'(p);
         wr(HCFG_WR_ADDR, 16'({pl, pl}) << CFG_DREQ_POL);
         wr(PCFG_WR_ADDR, 16'({pl, pl}) << CFG_DREQ_POL);
         rd(PCFG_RD_ADDR, 16'({pl, pl}) << CFG_DREQ_POL); // config readback
         @(posedge clock);
         {hostDmaNeed, periphDmaNeed} <= 2'b11;
         cyc(8);
         `CHK({hostDmaRequest, periphDmaRequest}, {pl, pl}) // active level
         `CHK({hostDmaGranted, periphDmaGranted}, 2'b11) // grant decoded
         @(posedge clock);
         {hostDmaNeed, periphDmaNeed} <= 2'b00;
         cyc(8);
         `CHK({hostDmaRequest, periphDmaRequest}, {~pl, ~pl}) // inactive level
         `CHK({hostDmaGranted, periphDmaGranted}, 2'b00) // grant withdrawn
      end
      $display("test dma done");
   endtask
   task automatic t_mrg_dma();
      wr(HCFG_WR_ADDR, 16'h0002);
      wr(PCFG_WR_ADDR, 16'h0000);
      @(posedge clock);
      periphDmaNeed <= 1'b1;
      cyc(8);
      `CHK({hostDmaRequest, periphDmaRequest, periphDmaGranted}, 3'b011) // routed to host pins
      @(posedge clock);
      hostDmaNeed <= 1'b1;
      cyc(8);
      `CHK({hostDmaGranted, periphDmaGranted}, 2'b10) // host channel first
      @(posedge clock);
      {hostDmaNeed, periphDmaNeed} <= 2'b00;
      wr(HCFG_WR_ADDR, 16'h0000);
      $display("test merged dma done");
   endtask
   task automatic t_irq();
      wr(IRQ_MASK_ADDR, 16'h000f);
      wr(HCFG_WR_ADDR, 16'h0030);
      wr(PCFG_WR_ADDR, 16'h0030);
      ev(2'b01);
      cyc(3);
      `CHK({irqOut, hostIrqOut, periphIrqOut}, 3'b110) // host event on host pin
      ev(2'b10);
      cyc(3);
      `CHK(periphIrqOut, 1'b1) // peripheral event on its pin
      rd(IRQ_STAT_ADDR, 16'h0003); // sticky status
      wr(IRQ_STAT_ADDR, 16'h0001);
      cyc(3);
      `CHK({hostIrqOut, periphIrqOut}, 2'b01) // cleared by writing one
      wr(PCFG_WR_ADDR, 16'h0010);
      cyc(3);
      `CHK(periphIrqOut, 1'b0) // disabled pin inactive
      wr(IRQ_MASK_ADDR, 16'h0000);
      cyc(1);
      `CHK(irqOut, 1'b0) // masked status raises nothing
      fork
         wr(IRQ_STAT_ADDR, 16'h000f);
         ev(2'b01);
      join
      wr(IRQ_MASK_ADDR, 16'h000f);
      rd(IRQ_STAT_ADDR, 16'h0001); // set wins clear
      $display("test irq done");
   endtask
   task automatic t_mrg_irq();
      wr(HCFG_WR_ADDR, 16'h0031);
      wr(PCFG_WR_ADDR, 16'h0030);
      ev(2'b10);
      cyc(3);
      `CHK({hostIrqOut, periphIrqOut}, 2'b10) // both onto host pin
      wr(IRQ_STAT_ADDR, 16'h000f);
      wr(HCFG_WR_ADDR, 16'h0000);
      wr(PCFG_WR_ADDR, 16'h0000);
      $display("test merged irq done");
   endtask
   task automatic t_susp(input int s);
      int i;
      @(posedge clock);
      {periphSuspendEnter, hostSuspendEnter} <= 2'(1 << s);
      @(posedge clock);
      {periphSuspendEnter, hostSuspendEnter} <= 2'b00;
      cyc(1);
      `CHK({swPin[s], s ? periphSuspended : hostSuspended}, 2'b11) // released high
      rd(SUSP_CTRL_ADDR, 16'(1 << s)); // suspended readback
      repeat (110) @(posedge clock);
      wakeCmd <= 2'(1 << s);
      @(posedge clock);
      wakeCmd <= 2'b00;
      i = 0;
      while ((s ? periphWake : hostWake) !== 1'b1 && i < 30) begin
         cyc(1);
         i++;
      end
      `CHK(s ? periphWake : hostWake, 1'b1) // low pulse wakes
      cyc(1);
      `CHK(s ? periphSuspended : hostSuspended, 1'b0) // left suspend
      i = 0;
      while (swPin[s] !== 1'b0 && i < 200) begin
         cyc(1);
         i++;
      end
      `CHK(swPin[s], 1'b0) // indication ends after resume
      rd(IRQ_STAT_ADDR, 16'(1 << (ST_HOST_WAKE + s))); // wake event recorded
      wr(IRQ_STAT_ADDR, 16'h000f);
      $display("test suspend %0d done", s);
   endtask

   // Ceiling far above what the scenarios need
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      cyc(1);
      t_reset();
      t_dma();
      t_mrg_dma();
      t_irq();
      t_mrg_irq();
      t_susp(0);
      t_susp(1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
